//--- test_watchdog_source_protection.sv
// self-checking bench for the source-protected watchdog
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_source_protection;
   localparam int D = 2;
   localparam int T = 4096 * D;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready = 1'b1;
   logic wait_mode = 1'b0, hreadyout, hresp, rst_req, irq, stop_req, osc_on, prot;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [7:0] boot = 8'h0;
   logic [14:0] c;
   logic good;
   int num_errors = 0, num_checks = 0, n;
   always #50 hclk = ~hclk;
   wdsp_top #(.OSC_DIV(D), .CPU_PRESCALE(D)) dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .boot_option_word(boot), .wait_mode(wait_mode),
      .wdt_reset_req(rst_req), .wdt_irq(irq), .stop_mode_request(stop_req),
      .low_speed_osc_on(osc_on), .source_protect_enable(prot));
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic edge_rdy();
      int k;
      k = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
      begin
         k++;
         if (k > 50)
         begin
            num_errors++;
            test_done();
         end
         @(posedge hclk);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      edge_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      edge_rdy();
      rd = hrdata;
   endtask
   task automatic do_reset(input logic [7:0] b);
      hresetn <= 1'b0;
      boot <= b;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
   endtask
   // refresh (00 then FF) reloads, 00, 5A, FF leaves the count running
   function automatic logic count_ok(input logic g, input logic [14:0] old, input logic [14:0] now);
      return g ? (now >= 15'h0FF8 && now <= 15'h0FFF) : (now < old);
   endfunction
   task automatic expire(input int lo);
      n = 0;
      while (rst_req !== 1'b1 && n < T + 100)
      begin
         @(negedge hclk);
         n++;
         if (irq !== 1'b0)
            chk("irq_in_protect", 32'h0, {31'h0, irq});
      end
      if (rst_req !== 1'b1)
      begin
         num_errors++;
         $display("ERROR period_timeout expected reset request seen none");
         test_done();
      end
      @(posedge hclk);
      chk("period_ok", 32'h1, {31'h0, n >= lo && n <= T + 2 * D + 4});
      xfer(1'b0, 8'h14, 32'h0);
      chk("reload_ok", 32'h1, {31'h0, rd[14:0] >= 15'h0FF8 && rd[14:0] <= 15'h0FFF});
   endtask
   initial
   begin
      void'($urandom(95));
      do_reset(8'h81);
      xfer(1'b0, 8'h14, 32'h0);
      chk("run_off", 32'h0, {31'h0, rd[16]});
      chk("prot_off", 32'h0, {31'h0, rd[17]});
      c = rd[14:0];
      xfer(1'b1, 8'h18, 32'h0);
      xfer(1'b0, 8'h18, 32'h0);
      chk("boot_word", 32'h81, rd);
      xfer(1'b0, 8'h1C, 32'h0);
      chk("unmapped", 32'h0, rd);
      repeat (300) @(posedge hclk);
      xfer(1'b0, 8'h14, 32'h0);
      chk("count_held", {17'h0, c}, {17'h0, rd[14:0]});
      xfer(1'b1, 8'h04, 32'h0);
      xfer(1'b1, 8'h0C, 32'h10);
      xfer(1'b0, 8'h14, 32'h0);
      chk("run_on", 32'h1, {31'h0, rd[16]});
      chk("osc_off", 32'h0, {31'h0, osc_on});
      $display("test start_control done");
      xfer(1'b1, 8'h08, 32'h80);
      xfer(1'b0, 8'h14, 32'h0);
      chk("prot_on", 32'h1, {31'h0, rd[17]});
      chk("load_ok", 32'h1, {31'h0, rd[14:0] >= 15'h0FF8 && rd[14:0] <= 15'h0FFF});
      chk("osc_back", 32'h1, {31'h0, osc_on});
      xfer(1'b0, 8'h10, 32'h0);
      chk("urs_set", 32'h1, {31'h0, rd[2]});
      xfer(1'b1, 8'h0C, 32'h11);
      xfer(1'b1, 8'h08, 32'h0);
      xfer(1'b0, 8'h0C, 32'h0);
      chk("clkmode_lock", 32'h0, {30'h0, rd[4], rd[0]});
      chk("no_stop", 32'h0, {31'h0, stop_req});
      chk("prot_kept", 32'h1, {31'h0, prot});
      $display("test protect_entry done");
      repeat (8)
      begin
         wait_mode <= 1'($urandom_range(0, 1));
         good = 1'($urandom_range(0, 1));
         repeat ($urandom_range(50, 900)) @(posedge hclk);
         xfer(1'b0, 8'h14, 32'h0);
         c = rd[14:0];
         xfer(1'b1, 8'h00, 32'h0);
         if (!good)
            xfer(1'b1, 8'h00, 32'h5A);
         xfer(1'b1, 8'h00, 32'hFF);
         xfer(1'b0, 8'h14, 32'h0);
         chk("refresh", 32'h1, {31'h0, count_ok(good, c, rd[14:0])});
      end
      $display("test refresh done");
      wait_mode <= 1'b1;
      xfer(1'b1, 8'h00, 32'h0);
      xfer(1'b1, 8'h00, 32'hFF);
      expire(T - D);
      $display("test protected_timeout done");
      do_reset(8'h00);
      xfer(1'b0, 8'h14, 32'h0);
      chk("auto_run", 32'h1, {31'h0, rd[16]});
      chk("boot_prot", 32'h1, {31'h0, rd[17]});
      xfer(1'b0, 8'h10, 32'h0);
      chk("boot_urs", 32'h1, {31'h0, rd[2]});
      expire(T - 2 * D - 8);
      $display("test boot_protect done");
      test_done();
   end
endmodule // test_watchdog_source_protection
`default_nettype wire

//--- wdsp_downcnt.sv
// watchdog down-counter with load and underflow pulse
`timescale 1ns/1ps
`default_nettype none
`include "wdsp_params.svh"
module wdsp_downcnt (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic load,
   input wire wdsp_pkg::wdsp_count_t load_val,
   input wire logic tick,
   output wdsp_pkg::wdsp_count_t count,
   output logic underflow
);
   wdsp_pkg::wdsp_count_t cnt_ff;
   wdsp_pkg::wdsp_count_t nxt_cnt;
   logic nxt_uf;

   always_comb
   begin
      nxt_cnt = cnt_ff;
      nxt_uf = 1'b0;
      if (load)
      begin
         nxt_cnt = load_val;
      end
      else if (tick)
      begin
         if (cnt_ff == 15'h0000)
         begin
            nxt_uf = 1'b1;
            nxt_cnt = load_val;
         end
         else
         begin
            nxt_cnt = cnt_ff - 15'h0001;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_ff <= `WDSP_PROT_LOAD;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign count = cnt_ff;
   assign underflow = nxt_uf;
endmodule // wdsp_downcnt
`default_nettype wire

//--- wdsp_params.svh
// constants for the source-protected watchdog: offsets, fields, resets, timing
`ifndef WDSP_PARAMS_SVH
`define WDSP_PARAMS_SVH

`define WDSP_OFS_REFRESH 8'h00
`define WDSP_OFS_START 8'h04
`define WDSP_OFS_PROTECT 8'h08
`define WDSP_OFS_CLKMODE 8'h0C
`define WDSP_OFS_PROCMODE 8'h10
`define WDSP_OFS_STATUS 8'h14
`define WDSP_OFS_BOOTWORD 8'h18

`define WDSP_BOOT_AUTOSTART_DIS_BIT 0
`define WDSP_BOOT_PROTECT_DEF_BIT 7
`define WDSP_PROTECT_EN_BIT 7
`define WDSP_STOP_REQ_BIT 0
`define WDSP_OSC_DIS_BIT 4
`define WDSP_URS_BIT 2
`define WDSP_STAT_RUN_BIT 16
`define WDSP_STAT_PROT_BIT 17

`define WDSP_REFRESH_FIRST 8'h00
`define WDSP_REFRESH_SECOND 8'hFF
`define WDSP_PROT_LOAD 15'h0FFF
`define WDSP_CPU_LOAD 15'h7FFF
`define WDSP_OSC_DIS_RST 1'b0
`define WDSP_URS_RST 1'b0
`define WDSP_STOP_REQ_RST 1'b0

`define WDSP_CLK_PERIOD_NS 100
`define WDSP_OSC_PERIOD_NS 8000
`define WDSP_OSC_DIV (`WDSP_OSC_PERIOD_NS / `WDSP_CLK_PERIOD_NS)
`define WDSP_CPU_PRESCALE 16

`endif

//--- wdsp_pkg.sv
// types shared by the source-protected watchdog
package wdsp_pkg;
   typedef logic [14:0] wdsp_count_t;
   typedef enum logic {WDSP_SEQ_IDLE, WDSP_SEQ_ARMED} wdsp_seq_e;
endpackage

//--- wdsp_properties.sv
// assertion checker for the source-protected watchdog
`timescale 1ns/1ps
`default_nettype none
module wdsp_checker #(
   parameter int OSC_DIV = 80,
   parameter int CPU_PRESCALE = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic wdt_reset_req,
   input wire logic wdt_irq,
   input wire logic stop_mode_request,
   input wire logic low_speed_osc_on,
   input wire logic source_protect_enable
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence prot_wr;
      hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h08 ##1 hwdata[7];
   endsequence
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   ready_high_a: assert property (hreadyout)
      else $error("slave inserted wait state");
   prot_write_a: assert property (prot_wr |=> source_protect_enable)
      else $error("protect write did not enable mode");
   prot_sticky_a: assert property (source_protect_enable |=> source_protect_enable)
      else $error("protected mode dropped");
   osc_locked_a: assert property (source_protect_enable |-> low_speed_osc_on)
      else $error("oscillator off in protected mode");
   stop_locked_a: assert property ($past(source_protect_enable) |-> $stable(stop_mode_request))
      else $error("stop request changed in protected mode");
   no_irq_a: assert property ($past(source_protect_enable) |-> !wdt_irq)
      else $error("interrupt raised in protected mode");
   pulse_once_a: assert property (wdt_reset_req |=> !wdt_reset_req [*2])
      else $error("reset request longer than one cycle");
   excl_pulse_a: assert property (!(wdt_reset_req && wdt_irq))
      else $error("reset and interrupt together");
   cover property ($rose(source_protect_enable));
   cover property (source_protect_enable && wdt_reset_req);
   cover property ($fell(low_speed_osc_on));
endmodule // wdsp_checker
bind wdsp_top wdsp_checker #(.OSC_DIV(OSC_DIV), .CPU_PRESCALE(CPU_PRESCALE)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .wdt_reset_req(wdt_reset_req), .wdt_irq(wdt_irq),
   .stop_mode_request(stop_mode_request), .low_speed_osc_on(low_speed_osc_on),
   .source_protect_enable(source_protect_enable));
`default_nettype wire

//--- wdsp_tick_div.sv
// enable-pulse divider off the system clock
`timescale 1ns/1ps
`default_nettype none
module wdsp_tick_div #(
   parameter int DIV = 80
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic run,
   output logic tick
);
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   logic tick_ff;
   logic nxt_tick;

   always_comb
   begin
      nxt_cnt = cnt_ff;
      nxt_tick = 1'b0;
      if (!run)
      begin
         nxt_cnt = 16'h0000;
      end
      else if (cnt_ff == 16'(DIV - 1))
      begin
         nxt_cnt = 16'h0000;
         nxt_tick = 1'b1;
      end
      else
      begin
         nxt_cnt = cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_ff <= 16'h0000;
         tick_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;
endmodule // wdsp_tick_div
`default_nettype wire

//--- wdsp_top.sv
// source-protected watchdog with AHB-Lite register slave
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "wdsp_params.svh"
module wdsp_top #(
   parameter int OSC_DIV = `WDSP_OSC_DIV,
   parameter int CPU_PRESCALE = `WDSP_CPU_PRESCALE
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [7:0] boot_option_word,
   input wire logic wait_mode,
   output logic wdt_reset_req,
   output logic wdt_irq,
   output logic stop_mode_request,
   output logic low_speed_osc_on,
   output logic source_protect_enable
);
   // bus state
   logic wr_pend_ff;
   logic nxt_wr_pend;
   logic [7:0] wr_addr_ff;
   logic [7:0] nxt_wr_addr;
   logic [31:0] hrdata_ff;
   logic [31:0] nxt_hrdata;
   logic hreadyout_ff;

   // control state
   logic boot_taken_ff;
   logic nxt_boot_taken;
   logic [7:0] boot_word_ff;
   logic [7:0] nxt_boot_word;
   logic running_ff;
   logic nxt_running;
   logic protect_ff;
   logic nxt_protect;
   logic osc_dis_ff;
   logic nxt_osc_dis;
   logic urs_ff;
   logic nxt_urs;
   logic stop_req_ff;
   logic nxt_stop_req;
   wdsp_pkg::wdsp_seq_e seq_ff;
   wdsp_pkg::wdsp_seq_e nxt_seq;
   logic rst_req_ff;
   logic nxt_rst_req;
   logic irq_ff;
   logic nxt_irq;
   logic load;
   logic load_prot;

   logic osc_tick;
   logic cpu_tick;
   logic cnt_tick;
   logic cnt_run;
   logic underflow;
   wdsp_pkg::wdsp_count_t count;
   wdsp_pkg::wdsp_count_t load_val;

   logic addr_phase;
   logic wr_now;
   logic [7:0] wbyte;

   assign addr_phase = hsel && htrans[1] && hready;
   assign wr_now = wr_pend_ff;
   assign wbyte = hwdata[7:0];

   // count source: oscillator in protected mode, prescaled CPU clock otherwise
   assign cnt_run = running_ff && (protect_ff || (!wait_mode && !stop_req_ff));
   assign cnt_tick = protect_ff ? osc_tick : cpu_tick;
   // a load that enters protected mode must already take the short range
   assign load_prot = protect_ff
      || (!boot_taken_ff && !boot_option_word[`WDSP_BOOT_PROTECT_DEF_BIT])
      || (boot_taken_ff && wr_now && wr_addr_ff == `WDSP_OFS_PROTECT
         && hwdata[`WDSP_PROTECT_EN_BIT]);
   assign load_val = load_prot ? `WDSP_PROT_LOAD : `WDSP_CPU_LOAD;

   wdsp_tick_div #(
      .DIV(OSC_DIV)
   ) u_osc_div (
      .hclk(hclk),
      .hresetn(hresetn),
      .run(cnt_run && !osc_dis_ff),
      .tick(osc_tick)
   );

   wdsp_tick_div #(
      .DIV(CPU_PRESCALE)
   ) u_cpu_div (
      .hclk(hclk),
      .hresetn(hresetn),
      .run(cnt_run),
      .tick(cpu_tick)
   );

   wdsp_downcnt u_cnt (
      .hclk(hclk),
      .hresetn(hresetn),
      .load(load),
      .load_val(load_val),
      .tick(cnt_tick && cnt_run),
      .count(count),
      .underflow(underflow)
   );

   // bus slave: zero wait, writes land in the data phase
   always_comb
   begin
      nxt_wr_pend = addr_phase && hwrite;
      nxt_wr_addr = addr_phase ? haddr[7:0] : wr_addr_ff;
      nxt_hrdata = hrdata_ff;
      if (addr_phase && !hwrite)
      begin
         nxt_hrdata = 32'h0000_0000;
         unique case (haddr[7:0])
            `WDSP_OFS_PROTECT: nxt_hrdata[`WDSP_PROTECT_EN_BIT] = protect_ff;
            `WDSP_OFS_CLKMODE:
            begin
               nxt_hrdata[`WDSP_STOP_REQ_BIT] = stop_req_ff;
               nxt_hrdata[`WDSP_OSC_DIS_BIT] = osc_dis_ff;
            end
            `WDSP_OFS_PROCMODE: nxt_hrdata[`WDSP_URS_BIT] = urs_ff;
            `WDSP_OFS_STATUS:
            begin
               nxt_hrdata[14:0] = count;
               nxt_hrdata[`WDSP_STAT_RUN_BIT] = running_ff;
               nxt_hrdata[`WDSP_STAT_PROT_BIT] = protect_ff;
            end
            `WDSP_OFS_BOOTWORD: nxt_hrdata[7:0] = boot_word_ff;
            default: nxt_hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         hrdata_ff <= 32'h0000_0000;
         hreadyout_ff <= 1'b1;
      end
      else
      begin
         wr_pend_ff <= nxt_wr_pend;
         wr_addr_ff <= nxt_wr_addr;
         hrdata_ff <= nxt_hrdata;
         hreadyout_ff <= 1'b1;
      end
   end

   // watchdog control
   always_comb
   begin
      nxt_boot_taken = 1'b1;
      nxt_boot_word = boot_word_ff;
      nxt_running = running_ff;
      nxt_protect = protect_ff;
      nxt_osc_dis = osc_dis_ff;
      nxt_urs = urs_ff;
      nxt_stop_req = stop_req_ff;
      nxt_seq = seq_ff;
      load = 1'b0;
      nxt_rst_req = 1'b0;
      nxt_irq = 1'b0;
      if (!boot_taken_ff)
      begin
         // boot word caught once, just after reset release
         nxt_boot_word = boot_option_word;
         nxt_running = !boot_option_word[`WDSP_BOOT_AUTOSTART_DIS_BIT];
         load = 1'b1;
         if (!boot_option_word[`WDSP_BOOT_PROTECT_DEF_BIT])
         begin
            nxt_protect = 1'b1;
            nxt_osc_dis = 1'b0;
            nxt_urs = 1'b1;
         end
      end
      else if (wr_now)
      begin
         unique case (wr_addr_ff)
            `WDSP_OFS_REFRESH:
            begin
               if (wbyte == `WDSP_REFRESH_FIRST)
               begin
                  nxt_seq = wdsp_pkg::WDSP_SEQ_ARMED;
               end
               else
               begin
                  nxt_seq = wdsp_pkg::WDSP_SEQ_IDLE;
                  if (wbyte == `WDSP_REFRESH_SECOND && seq_ff == wdsp_pkg::WDSP_SEQ_ARMED)
                  begin
                     load = 1'b1;
                  end
               end
            end
            `WDSP_OFS_START: nxt_running = 1'b1;
            `WDSP_OFS_PROTECT:
            begin
               if (hwdata[`WDSP_PROTECT_EN_BIT] && !protect_ff)
               begin
                  nxt_protect = 1'b1;
                  load = 1'b1;
                  nxt_osc_dis = 1'b0;
                  nxt_urs = 1'b1;
               end
            end
            `WDSP_OFS_CLKMODE:
            begin
               if (!protect_ff)
               begin
                  nxt_stop_req = hwdata[`WDSP_STOP_REQ_BIT];
                  nxt_osc_dis = hwdata[`WDSP_OSC_DIS_BIT];
               end
            end
            `WDSP_OFS_PROCMODE:
            begin
               if (!protect_ff)
               begin
                  nxt_urs = hwdata[`WDSP_URS_BIT];
               end
            end
            default: nxt_seq = seq_ff;
         endcase
      end
      if (underflow)
      begin
         nxt_rst_req = protect_ff || urs_ff;
         nxt_irq = !protect_ff && !urs_ff;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         boot_taken_ff <= 1'b0;
         boot_word_ff <= 8'hFF;
         running_ff <= 1'b0;
         protect_ff <= 1'b0;
         osc_dis_ff <= `WDSP_OSC_DIS_RST;
         urs_ff <= `WDSP_URS_RST;
         stop_req_ff <= `WDSP_STOP_REQ_RST;
         seq_ff <= wdsp_pkg::WDSP_SEQ_IDLE;
         rst_req_ff <= 1'b0;
         irq_ff <= 1'b0;
      end
      else
      begin
         boot_taken_ff <= nxt_boot_taken;
         boot_word_ff <= nxt_boot_word;
         running_ff <= nxt_running;
         protect_ff <= nxt_protect;
         osc_dis_ff <= nxt_osc_dis;
         urs_ff <= nxt_urs;
         stop_req_ff <= nxt_stop_req;
         seq_ff <= nxt_seq;
         rst_req_ff <= nxt_rst_req;
         irq_ff <= nxt_irq;
      end
   end

   assign hrdata = hrdata_ff;
   assign hreadyout = hreadyout_ff;
   assign hresp = 1'b0;
   assign wdt_reset_req = rst_req_ff;
   assign wdt_irq = irq_ff;
   assign stop_mode_request = stop_req_ff;
   assign low_speed_osc_on = !osc_dis_ff;
   assign source_protect_enable = protect_ff;
endmodule // wdsp_top
`default_nettype wire
